// *** include/iwm_map.svh ***
// Constants for the interrupt priority and wake map block
`ifndef IWM_MAP_SVH
`define IWM_MAP_SVH

`define IWM_NUM_IRQ 32
`define IWM_NUM_PRIO_REG 8
`define IWM_PRIO_W 2
`define IWM_PRIO_REG_SHIFT 2
`define IWM_PRIO_STRIDE 8
`define IWM_PRIO_BASE_BIT 6
`define IWM_PRIO_RESET 2'h0
`define IWM_VECTOR_OFFSET 6'h10
`define IWM_VECTOR_ADDR_SHIFT 2
`define IWM_NUM_SRC 13

// IRQ numbers of the routed sources
`define IWM_IRQ_PWR 5'h06
`define IWM_IRQ_SERIAL 5'h0C
`define IWM_IRQ_ADC 5'h0F
`define IWM_IRQ_CMP 5'h10
`define IWM_IRQ_TMR_A 5'h11
`define IWM_IRQ_TMR_B 5'h12
`define IWM_IRQ_RTC_ALARM 5'h14
`define IWM_IRQ_RTC_SEC 5'h15
`define IWM_IRQ_LPTMR 5'h1C
`define IWM_IRQ_PIN_A 5'h1E
`define IWM_IRQ_PIN_B 5'h1F

// Bit positions of the sources in the synchronised request vector
`define IWM_SRC_CMP 0
`define IWM_SRC_TMR_A 1
`define IWM_SRC_TMR_B 2
`define IWM_SRC_LPTMR 3
`define IWM_SRC_RTC_ALARM 4
`define IWM_SRC_RTC_SEC 5
`define IWM_SRC_SERIAL 6
`define IWM_SRC_ADC 7
`define IWM_SRC_PIN_A 8
`define IWM_SRC_PIN_B 9
`define IWM_SRC_LVD 10
`define IWM_SRC_LVW 11
`define IWM_SRC_RESET_PIN 12

`endif

// *** include/iwm_pkg.sv ***
// Types shared by the interrupt priority and wake map block
package iwm_pkg;

    // Raw requests, all from outside the system clock domain
    typedef struct packed {
        logic reset_pin;
        logic lvw;
        logic lvd;
        logic pin_b;
        logic pin_a;
        logic adc;
        logic serial;
        logic rtc_sec;
        logic rtc_alarm;
        logic lptmr;
        logic tmr_b;
        logic tmr_a;
        logic cmp;
    } iwm_src_s;

    // Qualifiers from logic on the system clock
    typedef struct packed {
        logic pin_a_en;
        logic pin_b_en;
        logic serial_clocked;
        logic tmr_a_clocked;
        logic tmr_b_clocked;
        logic lptmr_clocked;
        logic adc_clk_ok;
        logic reset_filt_lpo;
    } iwm_qual_s;

    typedef enum logic [1:0] {
        IWM_RUN = 2'b00,
        IWM_STOP = 2'b01,
        IWM_WAKE = 2'b10
    } iwm_wake_e;

endpackage : iwm_pkg

// *** hdl/iwm_prio_mem.sv ***
// Priority field store with a registered word read port
`timescale 1ns/1ps
`include "iwm_map.svh"

module iwm_prio_mem (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [4:0] wr_irq,
    input wire logic [1:0] wr_level,
    input wire logic [2:0] rd_index,
    output logic [31:0] rd_data_r,
    output logic [63:0] prio_flat
);

    logic [1:0] field_r [`IWM_NUM_IRQ];
    logic [31:0] word_sel;
    logic [31:0] rd_data_nxt;

    // ------------------------------------------------------------
    // Fields, one per IRQ
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `IWM_NUM_IRQ; gi++) begin : g_field
            logic [1:0] field_nxt;
            always_comb begin
                field_nxt = field_r[gi];
                if (wr_en && wr_irq == 5'(gi)) begin
                    field_nxt = wr_level; // RULE6
                end
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    field_r[gi] <= `IWM_PRIO_RESET;
                end else begin
                    field_r[gi] <= field_nxt;
                end
            end
            assign prio_flat[gi*2 +: 2] = field_r[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // Word view: register irq div 4, field at 8*(irq mod 4)+6
    // ------------------------------------------------------------
    always_comb begin
        word_sel = 32'h0;
        for (int k = 0; k < 4; k++) begin
            word_sel[`IWM_PRIO_STRIDE*k + `IWM_PRIO_BASE_BIT +: 2] =
                field_r[{rd_index, 2'(k)}]; // RULE4 RULE5
        end
        rd_data_nxt = word_sel;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= 32'h0;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

endmodule : iwm_prio_mem

// *** hdl/iwm_top.sv ***
// Interrupt routing, priority arbitration and stop-mode wake detection
//
// What this block does
// RULE1: The comparator edge request goes out as IRQ 16, vector 32.
// RULE2: The two PWM timer requests go out as IRQ 17 and IRQ 18.
// RULE3: The low-power timer compare request goes out as IRQ 28, vector 44.
// RULE4: An IRQ's priority sits in priority register number IRQ div 4.
// RULE5: Inside that register the field starts at bit 8*(IRQ mod 4)+6.
// RULE6: Each priority field is two bits wide, giving four levels.
// RULE7: In stop mode wake events are caught and clocking restart is asked.
// RULE8: After the restart the request stays pending and is serviced.
// RULE9: Any enabled pin interrupt wakes the device from stop.
// RULE10: Serial, PWM timer and low-power timer requests wake only if clocked.
// RULE11: The clock alarm and seconds requests each wake the device.
// RULE12: The comparator wakes the device in normal and in trigger mode.
// RULE13: Low-voltage detect and warning stay live in stop and wake it.
// RULE14: The reset pin wakes only when its filter runs on the slow oscillator.
// RULE15: The converter wakes only on its internal or crystal clock.
// RULE16: Each IRQ number equals its vector number minus 16.
// RULE17: The vector entry is fetched from four times the vector number.
`timescale 1ns/1ps
`include "iwm_map.svh"

module iwm_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire iwm_pkg::iwm_src_s src_raw,
    input wire iwm_pkg::iwm_qual_s qual,
    input wire logic [31:0] irq_enable,
    input wire logic stop_mode,
    input wire logic clk_restarted,
    input wire logic prio_wr_en,
    input wire logic [4:0] prio_wr_irq,
    input wire logic [1:0] prio_wr_level,
    input wire logic [2:0] prio_rd_index,
    output logic [31:0] prio_rd_data_r,
    output logic [31:0] irq_pending_r,
    output logic irq_valid_r,
    output logic [4:0] irq_num_r,
    output logic [5:0] irq_vector_r,
    output logic [7:0] vec_addr_r,
    output logic wake_req_r
);

    // ------------------------------------------------------------
    // Input synchronisers: a change counts once stages 2 and 3 agree
    // ------------------------------------------------------------
    logic [`IWM_NUM_SRC-1:0] raw_vec;
    logic [`IWM_NUM_SRC-1:0] s1_r, s2_r, s3_r, req_r;
    logic [`IWM_NUM_SRC-1:0] s1_nxt, s2_nxt, s3_nxt, req_nxt;

    assign raw_vec = src_raw;

    genvar gs;
    generate
        for (gs = 0; gs < `IWM_NUM_SRC; gs++) begin : g_sync
            always_comb begin
                s1_nxt[gs] = raw_vec[gs];
                s2_nxt[gs] = s1_r[gs];
                s3_nxt[gs] = s2_r[gs];
                req_nxt[gs] = (s2_r[gs] == s3_r[gs]) ? s3_r[gs] : req_r[gs];
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            req_r <= '0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
            req_r <= req_nxt;
        end
    end

    // ------------------------------------------------------------
    // Routing of sources onto IRQ lines
    // ------------------------------------------------------------
    logic [31:0] irq_line;
    logic [31:0] pending_nxt;

    always_comb begin
        irq_line = 32'h0;
        irq_line[`IWM_IRQ_PWR] = req_r[`IWM_SRC_LVD] | req_r[`IWM_SRC_LVW];
        irq_line[`IWM_IRQ_SERIAL] = req_r[`IWM_SRC_SERIAL];
        irq_line[`IWM_IRQ_ADC] = req_r[`IWM_SRC_ADC];
        irq_line[`IWM_IRQ_CMP] = req_r[`IWM_SRC_CMP]; // RULE1
        irq_line[`IWM_IRQ_TMR_A] = req_r[`IWM_SRC_TMR_A]; // RULE2
        irq_line[`IWM_IRQ_TMR_B] = req_r[`IWM_SRC_TMR_B]; // RULE2
        irq_line[`IWM_IRQ_RTC_ALARM] = req_r[`IWM_SRC_RTC_ALARM];
        irq_line[`IWM_IRQ_RTC_SEC] = req_r[`IWM_SRC_RTC_SEC];
        irq_line[`IWM_IRQ_LPTMR] = req_r[`IWM_SRC_LPTMR]; // RULE3
        irq_line[`IWM_IRQ_PIN_A] = req_r[`IWM_SRC_PIN_A] & qual.pin_a_en;
        irq_line[`IWM_IRQ_PIN_B] = req_r[`IWM_SRC_PIN_B] & qual.pin_b_en;
        // Level requests: a source stays pending while its line and its irq_enable bit are both high
        pending_nxt = irq_line & irq_enable; // RULE8
    end

    // ------------------------------------------------------------
    // Priority store
    // ------------------------------------------------------------
    logic [63:0] prio_flat;

    iwm_prio_mem iwm_prio_mem_i (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(prio_wr_en),
        .wr_irq(prio_wr_irq),
        .wr_level(prio_wr_level),
        .rd_index(prio_rd_index),
        .rd_data_r(prio_rd_data_r),
        .prio_flat(prio_flat)
    );

    // ------------------------------------------------------------
    // Arbitration: lowest level value wins, ties go to lower IRQ
    // ------------------------------------------------------------
    logic best_found;
    logic [4:0] best_irq;
    logic [1:0] best_lvl;
    logic valid_nxt;
    logic [4:0] num_nxt;
    logic [5:0] vector_nxt;
    logic [7:0] addr_nxt;

    always_comb begin
        best_found = 1'b0;
        best_irq = 5'h0;
        best_lvl = 2'h3;
        for (int i = 0; i < `IWM_NUM_IRQ; i++) begin
            if (irq_pending_r[i] &&
                (!best_found || prio_flat[i*2 +: 2] < best_lvl)) begin
                best_found = 1'b1;
                best_irq = 5'(i);
                best_lvl = prio_flat[i*2 +: 2]; // RULE6
            end
        end
        // Core stays idle while clocks are held for wake-up
        valid_nxt = best_found && !stop_mode;
        num_nxt = best_irq;
        vector_nxt = {1'b0, best_irq} + `IWM_VECTOR_OFFSET; // RULE16
        addr_nxt = {vector_nxt, 2'h0}; // RULE17
    end

    // ------------------------------------------------------------
    // Wake detector
    // ------------------------------------------------------------
    logic wake_any;
    iwm_pkg::iwm_wake_e wstate_r, wstate_nxt;
    logic wake_nxt;

    always_comb begin
        wake_any = 1'b0;
        wake_any = wake_any |
            (req_r[`IWM_SRC_PIN_A] & qual.pin_a_en) |
            (req_r[`IWM_SRC_PIN_B] & qual.pin_b_en); // RULE9
        wake_any = wake_any |
            (req_r[`IWM_SRC_SERIAL] & irq_enable[`IWM_IRQ_SERIAL] &
             qual.serial_clocked) |
            (req_r[`IWM_SRC_TMR_A] & irq_enable[`IWM_IRQ_TMR_A] &
             qual.tmr_a_clocked) |
            (req_r[`IWM_SRC_TMR_B] & irq_enable[`IWM_IRQ_TMR_B] &
             qual.tmr_b_clocked) |
            (req_r[`IWM_SRC_LPTMR] & irq_enable[`IWM_IRQ_LPTMR] &
             qual.lptmr_clocked); // RULE10
        wake_any = wake_any | req_r[`IWM_SRC_RTC_ALARM] |
            req_r[`IWM_SRC_RTC_SEC]; // RULE11
        // Comparator mode is not looked at: both modes raise the line
        wake_any = wake_any | req_r[`IWM_SRC_CMP]; // RULE12
        wake_any = wake_any | req_r[`IWM_SRC_LVD] |
            req_r[`IWM_SRC_LVW]; // RULE13
        wake_any = wake_any |
            (req_r[`IWM_SRC_RESET_PIN] & qual.reset_filt_lpo); // RULE14
        wake_any = wake_any |
            (req_r[`IWM_SRC_ADC] & qual.adc_clk_ok); // RULE15
    end

    always_comb begin
        wstate_nxt = wstate_r;
        wake_nxt = 1'b0;
        case (wstate_r)
            iwm_pkg::IWM_RUN: begin
                if (stop_mode) begin
                    wstate_nxt = iwm_pkg::IWM_STOP;
                end
            end
            iwm_pkg::IWM_STOP: begin
                // Leaving stop is looked at first, so a late source
                // cannot raise a wake for a device that already runs
                if (!stop_mode) begin
                    wstate_nxt = iwm_pkg::IWM_RUN;
                end else if (wake_any) begin
                    wstate_nxt = iwm_pkg::IWM_WAKE; // RULE7
                    wake_nxt = 1'b1;
                end
            end
            iwm_pkg::IWM_WAKE: begin
                // Held until clock control confirms, so a slow restart
                // cannot lose the request
                wake_nxt = 1'b1; // RULE7
                if (clk_restarted && !stop_mode) begin
                    wstate_nxt = iwm_pkg::IWM_RUN;
                    wake_nxt = 1'b0;
                end
            end
            default: begin
                wstate_nxt = iwm_pkg::IWM_RUN;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wstate_r <= iwm_pkg::IWM_RUN;
            wake_req_r <= 1'b0;
            irq_pending_r <= 32'h0;
            irq_valid_r <= 1'b0;
            irq_num_r <= 5'h0;
            irq_vector_r <= 6'h0;
            vec_addr_r <= 8'h0;
        end else begin
            wstate_r <= wstate_nxt;
            wake_req_r <= wake_nxt;
            irq_pending_r <= pending_nxt;
            irq_valid_r <= valid_nxt;
            irq_num_r <= num_nxt;
            irq_vector_r <= vector_nxt;
            vec_addr_r <= addr_nxt;
        end
    end

endmodule : iwm_top

// *** tb/iwm_top_monitor.sv ***
// Checker for the interrupt priority and wake map ports
`timescale 1ns/1ps
module iwm_top_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire iwm_pkg::iwm_src_s src_raw,
    input wire logic [31:0] irq_enable,
    input wire logic stop_mode,
    input wire logic clk_restarted,
    input wire logic prio_wr_en,
    input wire logic [31:0] irq_pending_r,
    input wire logic irq_valid_r,
    input wire logic [4:0] irq_num_r,
    input wire logic [5:0] irq_vector_r,
    input wire logic [7:0] vec_addr_r,
    input wire logic wake_req_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Request path and vector mapping
    // ------------------------------------------------------------
    a_vec_offset: assert property (irq_valid_r |->
        irq_vector_r == {1'h0, irq_num_r} + 6'h10)
        else $error("vector is not irq plus 16");
    a_vec_addr: assert property (irq_valid_r |->
        vec_addr_r == {irq_vector_r, 2'h0})
        else $error("vector address is not four times vector");
    a_valid_pend: assert property (irq_valid_r |->
        |($past(irq_pending_r) & (32'h1 << irq_num_r)))
        else $error("winner was not pending");
    a_stop_quiet: assert property (stop_mode [*2] |-> !irq_valid_r)
        else $error("request offered while stopped");
    a_pend_masked: assert property (
        (irq_pending_r & ~$past(irq_enable)) == 32'h0)
        else $error("disabled irq pending");
    // Source held past the filter: pending is due on the fifth edge
    a_route_cmp: assert property (
        $rose(src_raw.cmp) ##1 (src_raw.cmp && irq_enable[16]) [*5] |->
        irq_pending_r[16])
        else $error("comparator request not on irq 16");
    a_route_lptmr: assert property (
        $rose(src_raw.lptmr) ##1 (src_raw.lptmr && irq_enable[28]) [*5] |->
        irq_pending_r[28])
        else $error("low power timer request not on irq 28");
    // Wake must hold until clocks are back, or the core never restarts
    a_wake_hold: assert property (
        wake_req_r && !(clk_restarted && !stop_mode) |=> wake_req_r)
        else $error("wake request dropped early");
    a_wake_drop: assert property (
        wake_req_r && clk_restarted && !stop_mode |-> ##[1:2] !wake_req_r)
        else $error("wake request stuck after restart");
    a_wake_cause: assert property ($rose(wake_req_r) |-> $past(stop_mode))
        else $error("wake outside stop");
    c_wake: cover property ($rose(wake_req_r));
    c_lptmr: cover property (irq_valid_r && irq_num_r == 5'h1C);
    c_prio: cover property (prio_wr_en [*2]);
endmodule : iwm_top_monitor

bind iwm_top iwm_top_monitor iwm_top_monitor_i (.clk, .rst_n, .src_raw,
    .irq_enable, .stop_mode, .clk_restarted, .prio_wr_en, .irq_pending_r,
    .irq_valid_r, .irq_num_r, .irq_vector_r, .vec_addr_r, .wake_req_r);

// *** tb/iwm_core_model.sv ***
// Core and clock control stand-in: sleeps on request, restarts on wake
`timescale 1ns/1ps
module iwm_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sleep_req,
    input wire logic [3:0] dly,
    input wire logic wake_req,
    output logic stop_mode_r,
    output logic clk_restarted_r
);
    logic [3:0] cnt_r;
    // ------------------------------------------------------------
    // Restart after dly+1 edges of wake, so slow oscillator start is covered
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_mode_r <= 1'h0;
            clk_restarted_r <= 1'h0;
            cnt_r <= 4'h0;
        end else begin
            clk_restarted_r <= 1'h0;
            if (sleep_req) begin
                stop_mode_r <= 1'h1;
                cnt_r <= 4'h0;
            end else if (stop_mode_r && wake_req) begin
                cnt_r <= cnt_r + 4'h1;
                if (cnt_r == dly) begin
                    stop_mode_r <= 1'h0;
                    clk_restarted_r <= 1'h1;
                end
            end
        end
    end
endmodule : iwm_core_model

// *** tb/test_iwm_top.sv ***
// Self-checking bench for the interrupt priority and wake map
`timescale 1ns/1ps
module test_iwm_top;
    logic clk = 1'h0, rst_n = 1'h0, prio_wr_en = 1'h0, sleep_req = 1'h0;
    iwm_pkg::iwm_src_s src_raw = '0;
    iwm_pkg::iwm_qual_s qual = '0;
    logic [31:0] irq_enable = '1, prd, pend, exp;
    logic [4:0] prio_wr_irq = 5'h00, num;
    logic [1:0] prio_wr_level = 2'h0;
    logic [2:0] prio_rd_index = 3'h0;
    logic [5:0] vec;
    logic [7:0] vaddr;
    logic valid, wake, stop_mode, restarted;
    logic [3:0] dly = 4'h1;
    int n_fail = 0, tests_run = 0;
    logic [4:0] irq_of[13] = '{5'h10, 5'h11, 5'h12, 5'h1C, 5'h14, 5'h15,
        5'h0C, 5'h0F, 5'h1E, 5'h1F, 5'h06, 5'h06, 5'h00};
    logic [7:0] qm[13] = '{8'h00, 8'h10, 8'h08, 8'h04, 8'h00, 8'h00,
        8'h20, 8'h02, 8'h80, 8'h40, 8'h00, 8'h00, 8'h01};

    always #20 clk = ~clk;

    iwm_top iwm_top_i (.clk, .rst_n, .src_raw, .qual, .irq_enable,
        .stop_mode, .clk_restarted(restarted), .prio_wr_en, .prio_wr_irq,
        .prio_wr_level, .prio_rd_index, .prio_rd_data_r(prd),
        .irq_pending_r(pend), .irq_valid_r(valid), .irq_num_r(num),
        .irq_vector_r(vec), .vec_addr_r(vaddr), .wake_req_r(wake));
    iwm_core_model iwm_core_model_i (.clk, .rst_n, .sleep_req, .dly,
        .wake_req(wake), .stop_mode_r(stop_mode),
        .clk_restarted_r(restarted));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] lvl(input logic [4:0] n);
        // Distinct pattern per register, so a wrong index shows
        return (n[1:0] ^ {2{n[4]}}) + n[3:2];
    endfunction : lvl
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        tests_run++;
        if (got !== want) begin
            n_fail++;
            $display("Error at %0t: got %h want %h", $time, got, want);
        end
    endtask : chk
    task automatic final_report;
        if (n_fail == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    initial begin
        #200000;
        n_fail++;
        final_report;
    end

    initial begin
        cyc(4);
        rst_n = 1'h1;
        cyc(1);
        prio_wr_en = 1'h1;
        for (int n = 0; n < 32; n++) begin
            prio_wr_irq = 5'(n);
            prio_wr_level = lvl(5'(n));
            cyc(1);
        end
        prio_wr_en = 1'h0;
        for (int i = 0; i < 8; i++) begin
            prio_rd_index = 3'(i);
            cyc(2);
            exp = 32'h0;
            for (int j = 0; j < 4; j++)
                exp[8 * j + 6 +: 2] = lvl(5'(4 * i + j));
            chk(prd, exp);
        end
        qual = '1;
        for (int s = 0; s < 12; s++) begin
            src_raw = 13'h0001 << s;
            cyc(8);
            chk(pend, 32'h1 << irq_of[s]);
            chk(valid, 1'h1);
            chk(num, irq_of[s]);
            chk(vec, irq_of[s] + 6'h10);
            chk(vaddr, {irq_of[s] + 6'h10, 2'h0});
        end
        src_raw = 13'h0001;
        irq_enable[16] = 1'h0;
        cyc(8);
        chk(pend, 32'h0);
        irq_enable[16] = 1'h1;
        src_raw.tmr_a = 1'h1;
        cyc(8);
        chk(num, 5'h11);
        src_raw = '0;
        qual = '0;
        cyc(8);
        for (int s = 0; s < 13; s++) begin
            dly = s[0] ? 4'h1 : 4'hA;
            sleep_req = 1'h1;
            cyc(1);
            sleep_req = 1'h0;
            src_raw = 13'h0001 << s;
            // Clocked sources: clock present but the IRQ disabled
            if ((qm[s] & 8'h3C) != 8'h00) begin
                qual = qm[s];
                irq_enable[irq_of[s]] = 1'h0;
            end
            // Short waits: a fast restart drops wake three edges later
            cyc(6);
            if (qm[s] != 8'h00) begin
                chk(wake, 1'h0);
                qual = qm[s];
                irq_enable = '1;
                cyc(2);
            end
            chk(wake, 1'h1);
            for (int k = 0; k < 40 && stop_mode; k++)
                cyc(1);
            cyc(8);
            chk(wake, 1'h0);
            chk(valid, s < 12);
            chk(pend, s < 12 ? 32'h1 << irq_of[s] : 32'h0);
            src_raw = '0;
            qual = '0;
            cyc(8);
        end
        rst_n = 1'h0;
        cyc(2);
        chk(prd, 32'h0);
        chk(wake, 1'h0);
        rst_n = 1'h1;
        cyc(2);
        chk(pend, 32'h0);
        chk(valid, 1'h0);
        chk(wake, 1'h0);
        chk(prd, 32'h0);
        final_report;
    end
endmodule : test_iwm_top
